// *** design/spi_map.svh ***
`ifndef SPI_MAP_SVH
`define SPI_MAP_SVH

// ----------------------------------------
// Register offsets, data space
// ----------------------------------------
`define CTRL_OFF 8'h4c
`define STAT_OFF 8'h4d
`define DATA_OFF 8'h4e
`define IO_DELTA 8'h20

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define CTRL_RESET 8'h00
`define RXBUF_RESET 8'h00
`define DBL_BIT 0
`define STAT_PAD 5'h00
`define READ_IDLE 8'h00

// ----------------------------------------
// Transfer counts
// ----------------------------------------
`define LAST_EDGE 5'h0f
`define EDGE_ZERO 5'h00
`define EDGE_STEP 5'h01

// ----------------------------------------
// Half periods of SCK in system clocks
// ----------------------------------------
`define HALF_DIV2 7'h01
`define HALF_DIV4 7'h02
`define HALF_DIV8 7'h04
`define HALF_DIV16 7'h08
`define HALF_DIV32 7'h10
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40

`endif

// *** design/spi_pkg.sv ***
package spi_pkg;
  typedef struct packed {
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic master;
    logic cpol;
    logic cpha;
    logic [1:0] rate;
  } ctrl_t;

  typedef struct packed {
    logic sample;
    logic setup;
    logic load;
    logic clear;
  } shift_cmd_t;

  typedef enum logic [1:0] {st_idle, st_wait, st_run} mstate_t;
endpackage

// *** design/spi_port.sv ***
`include "spi_map.svh"
// Function
// - Shift out on one SCK edge, sample on the other; modes 0-3 map to pairs.
// - Polarity one idles SCK high; zero idles it low.
// - Phase zero samples on leading edge; phase one samples on trailing edge.
// - Interrupt asserts when flag, enable bit and global enable are all set.
// - Nothing happens while the port enable bit is zero.
// - Bit order one sends LSB first, zero sends MSB first.
// - Master select; slave-select low as input clears it and sets flag.
// - Normal speed divides system clock by 4, 16, 64 or 128.
// - Double speed master divides system clock by 2, 8, 32 or 64.
// - Rate select bits have no effect in slave mode.
// - Transfer complete flag sets when a byte finishes.
// - Interrupt acknowledge clears the transfer complete flag.
// - Status read with flag set, then data access, clears the flag.
// - Data write during a transfer sets the collision flag.
// - Status read with collision set, then data access, clears both flags.
// - Data register write starts shifting out the written byte.
// - Data register read returns the receive buffer.
// - Registers answer at data offset and at offset minus 0x20.
// - Master shifts eight bits per write, then stops its clock.
// - Slave-select high resets slave logic and drops partial bits.
// - Transmit single buffered, receive double buffered.
// - Slave-select as master output does not affect the port.
module spi_port
  import spi_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic io_space_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic global_irq_en_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  input wire logic ss_is_output_i
);
  import spi_pkg::*;

  ctrl_t ctrl;
  mstate_t state;
  logic dbl;
  logic spif;
  logic wcol;
  logic spif_arm;
  logic wcol_arm;
  logic [7:0] rxbuf;
  logic [4:0] edge_cnt;
  logic sck_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [7:0] dspace = io_space_i ? 8'(addr_i + `IO_DELTA) : addr_i;
  wire sel_ctrl = (dspace == `CTRL_OFF);
  wire sel_stat = (dspace == `STAT_OFF);
  wire sel_data = (dspace == `DATA_OFF);
  wire ctrl_wr = wr_i && sel_ctrl;
  wire stat_wr = wr_i && sel_stat;
  wire stat_rd = rd_i && sel_stat;
  wire data_wr = wr_i && sel_data;
  wire data_rd = rd_i && sel_data;
  wire data_acc = (wr_i || rd_i) && sel_data;
  wire [7:0] stat_val = {spif, wcol, `STAT_PAD, dbl};
  wire [7:0] rmux = sel_ctrl ? ctrl :
                    sel_stat ? stat_val :
                    sel_data ? rxbuf : `READ_IDLE;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire master_on = ctrl.port_en && ctrl.master;
  // In master mode, slave-select is only looked at while it is an input; slave mode uses it either way
  wire mode_fault = master_on && !ss_is_output_i && !ss_n_i;
  wire slave_on = ctrl.port_en && !ctrl.master && !ss_n_i;
  wire core_busy;
  wire core_done;
  wire core_out;
  wire [W-1:0] core_rx;
  wire busy = (state != st_idle) || core_busy;
  wire start = data_wr && master_on && !mode_fault && (state == st_idle);
  wire load = data_wr && !busy;
  wire wcol_set = data_wr && busy;

  // ----------------------------------------
  // Master edge timing
  // ----------------------------------------
  wire tick;
  wire m_lead = !edge_cnt[0];
  wire m_sample = tick && (m_lead ^ ctrl.cpha);
  wire m_setup = tick && !(m_lead ^ ctrl.cpha);
  wire m_last = tick && (edge_cnt == `LAST_EDGE);

  // ----------------------------------------
  // Slave edge timing
  // ----------------------------------------
  // SCK is sampled, so the remote clock must stay slow enough to see both levels
  wire s_edge = slave_on && (sck_i != sck_q);
  wire s_lead = (sck_i != ctrl.cpol);
  wire s_sample = s_edge && (s_lead ^ ctrl.cpha);
  wire s_setup = s_edge && !(s_lead ^ ctrl.cpha);
  wire s_done = slave_on && core_done;

  wire xfer_done = m_last || s_done;
  wire spif_set = xfer_done || mode_fault;
  wire spif_clr = irq_ack_i || (data_acc && (spif_arm || wcol_arm));
  wire wcol_clr = data_acc && wcol_arm;

  shift_cmd_t cmd;
  assign cmd.sample = m_sample || s_sample;
  assign cmd.setup = m_setup || s_setup;
  assign cmd.load = load;
  assign cmd.clear = !(slave_on || master_on);

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  spi_rate_gen #(
    .CW(7)
  ) u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state == st_run),
    .double_i(dbl),
    .rate_i(ctrl.rate),
    .tick_o(tick)
  );

  spi_shift_core #(
    .W(W)
  ) u_core (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_i(cmd),
    .lsb_first_i(ctrl.lsb_first),
    .load_data_i(wdata_i),
    .in_bit_i(ctrl.master ? miso_i : mosi_i),
    .out_bit_o(core_out),
    .busy_o(core_busy),
    .done_o(core_done),
    .rx_o(core_rx)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (mode_fault) begin
      ctrl.master <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dbl <= 1'b0;
    end else if (stat_wr) begin
      dbl <= wdata_i[`DBL_BIT];
    end
  end

  // Hardware set wins over any clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      spif <= 1'b0;
      wcol <= 1'b0;
    end else begin
      spif <= spif_set || (spif && !spif_clr);
      wcol <= wcol_set || (wcol && !wcol_clr);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      spif_arm <= 1'b0;
      wcol_arm <= 1'b0;
    end else if (stat_rd) begin
      spif_arm <= spif;
      wcol_arm <= wcol;
    end else if (data_acc) begin
      spif_arm <= 1'b0;
      wcol_arm <= 1'b0;
    end
  end

  // Old byte stays readable until the next one is complete
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxbuf <= `RXBUF_RESET;
    end else if (core_done) begin
      rxbuf <= core_rx;
    end
  end

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  // One wait cycle lets the first bit settle on MOSI before any SCK edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= st_idle;
    end else if (!master_on || mode_fault) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (start) begin
            state <= st_wait;
          end
        end
        st_wait: begin
          state <= st_run;
        end
        st_run: begin
          if (m_last) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_cnt <= `EDGE_ZERO;
    end else if (state != st_run) begin
      edge_cnt <= `EDGE_ZERO;
    end else if (tick) begin
      edge_cnt <= edge_cnt + `EDGE_STEP;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Data pins come straight off the shifter flop; a second stage would lag SCK at /2
  assign mosi_o = core_out;
  assign miso_o = core_out;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      if (state != st_run) begin
        sck_o <= ctrl.cpol;
      end else if (tick) begin
        sck_o <= !sck_o;
      end
      sck_oe_o <= master_on;
      mosi_oe_o <= master_on;
      miso_oe_o <= slave_on;
      sck_q <= sck_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      rdata_o <= `READ_IDLE;
    end else begin
      irq_o <= spif && ctrl.irq_en && global_irq_en_i;
      rdata_o <= rd_i ? rmux : `READ_IDLE;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_arm_flag;
    stat_rd && spif && !spif_set;
  endsequence

  sequence s_clear_access;
    data_acc && !spif_set;
  endsequence

  a_irq_request: assert property ((spif && ctrl.irq_en && global_irq_en_i) |=> irq_o)
    else $error("interrupt not raised");
  a_disabled_idle: assert property (!ctrl.port_en |=> state == st_idle && !sck_oe_o)
    else $error("port active while disabled");
  a_fault_handling: assert property (mode_fault |=> !ctrl.master && spif)
    else $error("mode fault not handled");
  a_collision_set: assert property (wcol_set |=> wcol)
    else $error("collision flag missed");
  a_flag_clear: assert property (s_arm_flag ##1 !spif_set ##1 s_clear_access |=> !spif)
    else $error("flag not cleared by access");
  a_ack_clear: assert property (irq_ack_i && !spif_set |=> !spif)
    else $error("flag not cleared by acknowledge");
  a_sck_idle: assert property (state == st_idle |=> sck_o == $past(ctrl.cpol))
    else $error("SCK not at idle level");
  a_master_bytelen: assert property (m_last |->
    edge_cnt == `LAST_EDGE && (ctrl.cpha ? core_done : !core_busy))
    else $error("master byte length wrong");
  a_slave_reset: assert property (ctrl.port_en && !ctrl.master && ss_n_i |=> !core_busy)
    else $error("slave not reset by select");
  a_read_buffer: assert property (data_rd |=> rdata_o == $past(rxbuf))
    else $error("data read mismatch");
endmodule

// *** design/spi_rate_gen.sv ***
`include "spi_map.svh"
module spi_rate_gen #(
  parameter int CW = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic double_i,
  input wire logic [1:0] rate_i,
  output logic tick_o
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] half;
  logic [CW-1:0] half_norm;
  logic [CW-1:0] half_dbl;

  // ----------------------------------------
  // Divider selection
  // ----------------------------------------
  assign half_norm = (rate_i == 2'h0) ? CW'(`HALF_DIV4) :
                     (rate_i == 2'h1) ? CW'(`HALF_DIV16) :
                     (rate_i == 2'h2) ? CW'(`HALF_DIV64) : CW'(`HALF_DIV128);
  assign half_dbl = (rate_i == 2'h0) ? CW'(`HALF_DIV2) :
                    (rate_i == 2'h1) ? CW'(`HALF_DIV8) :
                    (rate_i == 2'h2) ? CW'(`HALF_DIV32) : CW'(`HALF_DIV64);
  assign half = double_i ? half_dbl : half_norm;
  assign tick_o = run_i && (cnt == half - CW'(1));

  // Counter held at zero while stopped, so each byte starts a full half period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (!run_i || tick_o) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule

// *** design/spi_shift_core.sv ***
module spi_shift_core
  import spi_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input spi_pkg::shift_cmd_t cmd_i,
  input wire logic lsb_first_i,
  input wire logic [W-1:0] load_data_i,
  input wire logic in_bit_i,
  output logic out_bit_o,
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] rx_o
);
  localparam int CNW = $clog2(W);
  logic [W-1:0] sr;
  logic [W-1:0] shifted;
  logic [CNW-1:0] cnt;
  logic top_now;
  logic top_load;

  // ----------------------------------------
  // Bit order
  // ----------------------------------------
  assign shifted = lsb_first_i ? {in_bit_i, sr[W-1:1]} : {sr[W-2:0], in_bit_i};
  assign top_now = lsb_first_i ? sr[0] : sr[W-1];
  assign top_load = lsb_first_i ? load_data_i[0] : load_data_i[W-1];
  assign done_o = cmd_i.sample && (cnt == CNW'(W - 1));
  assign busy_o = (cnt != '0);
  assign rx_o = shifted;

  // Sampling shifts at once; the out bit moves only on load, clear and setup edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr <= '0;
      cnt <= '0;
      out_bit_o <= 1'b0;
    end else begin
      if (cmd_i.load) begin
        sr <= load_data_i;
      end else if (cmd_i.sample) begin
        sr <= shifted;
      end
      if (cmd_i.load || cmd_i.clear) begin
        cnt <= '0;
      end else if (cmd_i.sample) begin
        cnt <= cnt + CNW'(1);
      end
      if (cmd_i.load) begin
        out_bit_o <= top_load;
      end else if (cmd_i.clear || cmd_i.setup) begin
        out_bit_o <= top_now;
      end
    end
  end
endmodule

// *** test/spi_remote.sv ***
module spi_remote (
  input wire logic clk_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] rx_byte = 8'h00;
  logic [3:0] idx = 4'h0;
  logic mastering = 1'b0;
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b0;
  end
  function automatic logic pick(input logic [7:0] b, input logic [3:0] i);
    return lsb_i ? b[i[2:0]] : b[3'h7 - i[2:0]];
  endfunction
  function automatic logic [7:0] shin(input logic [7:0] r, input logic b);
    return lsb_i ? {b, r[7:1]} : {r[6:0], b};
  endfunction
  // ----------------------------------------
  // Slave side
  // ----------------------------------------
  always @(cpol_i) if (!mastering) sck_o = cpol_i;
  // Released line flips, so a stale bit never looks valid
  always @(posedge ss_n_i) miso_o = ~miso_o;
  always @(negedge ss_n_i) begin
    idx = 4'h0;
    if (!mastering) miso_o = pick(tx_byte, idx);
  end
  always @(sck_i) begin
    if (!ss_n_i && !mastering) begin
      if ((sck_i !== cpol_i) !== cpha_i) begin
        rx_byte = shin(rx_byte, mosi_i);
        idx = idx + 4'h1;
      end else begin
        miso_o = pick(tx_byte, idx);
      end
    end
  end
  // ----------------------------------------
  // Master side
  // ----------------------------------------
  // Half period of two clocks or more
  task automatic drive(input logic [7:0] b, input int nbits, input int half);
    mastering = 1'b1;
    rx_byte = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      if (!cpha_i) mosi_o = pick(b, 4'(i));
      repeat (half) @(posedge clk_i);
      #1 sck_o = ~sck_o;
      if (cpha_i) mosi_o = pick(b, 4'(i));
      else rx_byte = shin(rx_byte, miso_i);
      repeat (half) @(posedge clk_i);
      #1 sck_o = ~sck_o;
      if (cpha_i) rx_byte = shin(rx_byte, miso_i);
    end
    repeat (half) @(posedge clk_i);
    #1 mosi_o = ~mosi_o;
    mastering = 1'b0;
  endtask
endmodule

// *** test/testbench.sv ***
`include "spi_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic io_space_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic global_irq_en_i = 1'b0;
  logic irq_ack_i = 1'b0;
  logic ss_n_i = 1'b1;
  logic ss_is_output_i = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic lsb = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic remote_sck, remote_mosi, remote_miso;
  wire sck_w = sck_oe_o ? sck_o : remote_sck;
  wire mosi_w = mosi_oe_o ? mosi_o : remote_mosi;
  wire miso_w = miso_oe_o ? miso_o : remote_miso;
  int err_total = 0;
  int n_checks = 0;
  int gap = 0;
  int cnt = 0;
  int tog = 0;
  int divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic last_sck = 1'b0;
  logic [7:0] got = 8'h00;
  spi_port #(.W(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .io_space_i(io_space_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i),
    .irq_o(irq_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i),
    .ss_is_output_i(ss_is_output_i));
  spi_remote remote (.clk_i(clk_i), .sck_i(sck_w), .mosi_i(mosi_w),
    .miso_i(miso_w), .ss_n_i(ss_n_i), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb),
    .sck_o(remote_sck), .mosi_o(remote_mosi), .miso_o(remote_miso));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // SCK toggle count and spacing in system clocks
  always @(posedge clk_i) begin
    cnt = cnt + 1;
    if (sck_o !== last_sck) begin
      gap = cnt;
      cnt = 0;
      tog = tog + 1;
    end
    last_sck = sck_o;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic io);
    addr_i = io ? a - `IO_DELTA : a;
    io_space_i = io;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    @(posedge clk_i);
    #1 wr_i = 1'b0;
    rd_i = 1'b0;
    got = rdata_o;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wait_flag();
    for (int i = 0; i < 1000; i++) begin
      bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
      if (got[7] === 1'b1) return;
    end
    err_total++;
    results();
  endtask
  task automatic sel(input logic [2:0] m);
    ss_n_i = 1'b1;
    {cpol, cpha, lsb} = m;
    @(posedge clk_i);
    #1 ss_n_i = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    bus(1'b0, `CTRL_OFF, 8'h00, 1'b1);
    chk(got, `CTRL_RESET);
    bus(1'b1, `CTRL_OFF, 8'h2a, 1'b1);
    bus(1'b0, `CTRL_OFF, 8'h00, 1'b0);
    chk(got, 8'h2a);
    bus(1'b1, `STAT_OFF, 8'hff, 1'b0);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b1);
    chk(got, 8'h01);
    bus(1'b0, 8'h4f, 8'h00, 1'b0);
    chk(got, 8'h00);
  endtask
  task automatic t_master();
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `STAT_OFF, {7'h00, k[2]}, 1'b0);
      bus(1'b1, `CTRL_OFF, {2'b01, k[2], 1'b1, k[1], k[0], k[1], k[0]}, 1'b0);
      remote.tx_byte = 8'h3c + 8'(k);
      sel({k[1], k[0], k[2]});
      tog = 0;
      bus(1'b1, `DATA_OFF, 8'ha5 ^ 8'(k), 1'b0);
      wait_flag();
      chk(8'(tog), 8'h10);
      chk(8'(gap), 8'(divs[k] / 2));
      chk({7'h00, sck_o}, {7'h00, cpol});
      chk({6'h00, mosi_oe_o, miso_oe_o}, 8'h02);
      chk(remote.rx_byte, 8'ha5 ^ 8'(k));
      bus(1'b0, `DATA_OFF, 8'h00, 1'b0);
      chk(got, 8'h3c + 8'(k));
    end
  endtask
  task automatic t_collide();
    bus(1'b1, `STAT_OFF, 8'h00, 1'b0);
    bus(1'b1, `CTRL_OFF, 8'h53, 1'b0);
    sel(3'b000);
    bus(1'b1, `DATA_OFF, 8'h81, 1'b0);
    bus(1'b1, `DATA_OFF, 8'h7e, 1'b0);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
    chk(got, 8'h40);
    wait_flag();
    chk(got, 8'hc0);
    bus(1'b0, `DATA_OFF, 8'h00, 1'b0);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
    chk(got, 8'h00);
    chk(remote.rx_byte, 8'h81);
  endtask
  task automatic t_irq();
    bus(1'b1, `CTRL_OFF, 8'hd0, 1'b0);
    bus(1'b1, `DATA_OFF, 8'h5a, 1'b0);
    wait_flag();
    chk({7'h00, irq_o}, 8'h00);
    global_irq_en_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h00, irq_o}, 8'h01);
    irq_ack_i = 1'b1;
    @(posedge clk_i);
    #1 irq_ack_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h00, irq_o}, 8'h00);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
    chk(got, 8'h00);
    global_irq_en_i = 1'b0;
  endtask
  task automatic t_fault();
    bus(1'b1, `CTRL_OFF, 8'h50, 1'b0);
    ss_is_output_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    bus(1'b0, `CTRL_OFF, 8'h00, 1'b0);
    chk(got, 8'h40);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
    chk(got, 8'h80);
    bus(1'b0, `DATA_OFF, 8'h00, 1'b0);
    ss_n_i = 1'b1;
    ss_is_output_i = 1'b1;
  endtask
  task automatic t_off();
    bus(1'b1, `CTRL_OFF, 8'h10, 1'b0);
    bus(1'b1, `DATA_OFF, 8'h33, 1'b0);
    tog = 0;
    repeat (40) @(posedge clk_i);
    #1;
    chk({7'h00, sck_oe_o}, 8'h00);
    chk(8'(tog), 8'h00);
    bus(1'b0, `STAT_OFF, 8'h00, 1'b0);
    chk(got, 8'h00);
  endtask
  task automatic t_slave();
    bus(1'b1, `CTRL_OFF, 8'h47, 1'b0);
    bus(1'b1, `DATA_OFF, 8'h96, 1'b0);
    sel(3'b010);
    remote.drive(8'hff, 3, 4);
    sel(3'b010);
    remote.drive(8'h5b, 8, 4);
    wait_flag();
    bus(1'b0, `DATA_OFF, 8'h00, 1'b0);
    chk(got, 8'h5b);
    chk({6'h00, mosi_oe_o, miso_oe_o}, 8'h01);
    bus(1'b1, `DATA_OFF, 8'hc3, 1'b0);
    sel(3'b010);
    remote.drive(8'h00, 8, 4);
    wait_flag();
    chk(remote.rx_byte, 8'hc3);
    bus(1'b0, `DATA_OFF, 8'h00, 1'b0);
    chk(got, 8'h00);
    ss_n_i = 1'b1;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_regs();
    t_master();
    t_collide();
    t_irq();
    t_fault();
    t_off();
    t_slave();
    results();
  end
endmodule
